// >>> cbt_bit_timing.sv
// What this block does
// - Flag set takes three samples of each received bit, flag clear takes one.
// - The bus is sampled at the end of the first segment, where it meets the second.
// - Register writes are taken only in init mode; outside it a write is refused and wrRefused pulses.
// - The second segment lasts its field plus one quanta, code zero being invalid.
// - The first segment lasts its field plus one quanta, code zero being invalid.
`timescale 1ns/10ps
`include "cbt_map.svh"

module cbt_bit_timing (
    input  wire logic                 mclk,
    input  wire logic                 reset,
    input  wire logic                 cmdValid,
    input  wire logic [7:0]           cmdOpcode,
    input  wire logic [7:0]           cmdWrData,
    input  wire logic [2:0]           modeField,
    input  wire logic                 quantumTick,
    input  wire logic                 canRxPin,
    output logic [7:0]                rdData,
    output logic                      wrRefused,
    output cbt_pkg::cbt_segments_t    segments,
    output logic                      cfgValid,
    output logic                      samplePoint,
    output logic                      bitStart,
    output logic                      rxBit
);

    cbt_pkg::cbt_state_t s;
    cbt_pkg::cbt_state_t n;
    logic                voteBit;
    logic                seg1Last;
    logic                seg2Last;
    logic [4:0]          len1;
    logic [4:0]          len2;

    ////////////////////////////////////////////////////////////////////////
    // Majority vote over the synchronised line
    cbt_sampler u_sampler (
        .mclk        (mclk),
        .reset       (reset),
        .quantumTick (quantumTick),
        .rxIn        (s.rxSync),
        .voteBit     (voteBit)
    );

    // Last quantum of each segment: count runs from zero to the field code
    assign seg1Last = (s.tqCnt == s.segments.firstSegmentLen);
    assign seg2Last = (s.tqCnt == {1'b0, s.segments.secondSegmentLen});

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        n             = s;
        n.rxMeta      = canRxPin;
        n.rxSync      = s.rxMeta;
        n.samplePoint = 1'b0;
        n.bitStart    = 1'b0;
        n.wrRefused   = 1'b0;
        // Register access; a refused write leaves the timing untouched
        if (cmdValid && cmdOpcode == `CBT_OPC_WRITE) begin
            if (modeField[`CBT_MODE_INIT_BIT]) begin
                n.segments = cmdWrData;
            end else begin
                n.wrRefused = 1'b1;
            end
        end
        if (cmdValid && cmdOpcode == `CBT_OPC_READ) begin
            n.rdData = s.segments;
        end
        // Bit time walk, one step per quantum
        if (quantumTick) begin
            unique case (s.phase)
                cbt_pkg::CBT_SYNC: begin
                    n.phase    = cbt_pkg::CBT_SEG1;
                    n.tqCnt    = '0;
                end
                cbt_pkg::CBT_SEG1: begin
                    if (seg1Last) begin
                        n.phase       = cbt_pkg::CBT_SEG2;
                        n.tqCnt       = '0;
                        n.samplePoint = 1'b1;
                        // Triple vote or the single current sample
                        n.rxBit       = s.segments.tripleSampleSelect ? voteBit : s.rxSync;
                    end else begin
                        n.tqCnt = s.tqCnt + 4'h1;
                    end
                end
                cbt_pkg::CBT_SEG2: begin
                    if (seg2Last) begin
                        n.phase    = cbt_pkg::CBT_SYNC;
                        n.tqCnt    = '0;
                        n.bitStart = 1'b1;
                    end else begin
                        n.tqCnt = s.tqCnt + 4'h1;
                    end
                end
                default: begin
                    // Illegal code: restart the bit
                    n.phase = cbt_pkg::CBT_SYNC;
                    n.tqCnt = '0;
                end
            endcase
        end
        // Advisory check of host settings; jump width is held elsewhere
        n.cfgValid = (n.segments.secondSegmentLen != 3'h0) && (n.segments.firstSegmentLen != 4'h0)
                   && (n.segments.firstSegmentLen >= {1'b0, n.segments.secondSegmentLen})
                   && (5'h01 + {1'b0, n.segments.firstSegmentLen} + 5'h01
                       + {2'h0, n.segments.secondSegmentLen} + 5'h01 >= `CBT_MIN_BIT_TQ);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s          <= '0;
            s.segments <= `CBT_REG_RESET;
        end else begin
            s <= n;
        end
    end

    // Outputs straight from flops
    assign rdData      = s.rdData;
    assign wrRefused   = s.wrRefused;
    assign segments    = s.segments;
    assign cfgValid    = s.cfgValid;
    assign samplePoint = s.samplePoint;
    assign bitStart    = s.bitStart;
    assign rxBit       = s.rxBit;

    // Segment lengths in quanta, for checking only
    assign len1 = {1'b0, s.segments.firstSegmentLen} + 5'h01;
    assign len2 = {2'h0, s.segments.secondSegmentLen} + 5'h01;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_write_blocked;
        @(posedge mclk) disable iff (reset)
        (cmdValid && cmdOpcode == `CBT_OPC_WRITE && !modeField[`CBT_MODE_INIT_BIT])
        |=> (segments == $past(segments)) && wrRefused;
    endproperty
    a_write_blocked: assert property (p_write_blocked) else $error("write outside init mode changed timing");

    property p_seg2_len;
        @(posedge mclk) disable iff (reset)
        (s.phase == cbt_pkg::CBT_SEG2 && quantumTick && {1'b0, s.tqCnt} == len2 - 5'h01)
        |=> (s.phase == cbt_pkg::CBT_SYNC) && bitStart;
    endproperty
    a_seg2_len: assert property (p_seg2_len) else $error("second segment length wrong");

    property p_seg1_len;
        @(posedge mclk) disable iff (reset)
        (s.phase == cbt_pkg::CBT_SEG1 && quantumTick && {1'b0, s.tqCnt} < len1 - 5'h01)
        |=> (s.phase == cbt_pkg::CBT_SEG1) && !samplePoint;
    endproperty
    a_seg1_len: assert property (p_seg1_len) else $error("first segment ended early");

    property p_sample_at_seg1_end;
        @(posedge mclk) disable iff (reset)
        samplePoint |-> $past(s.phase) == cbt_pkg::CBT_SEG1 && s.phase == cbt_pkg::CBT_SEG2 && s.tqCnt == 4'h0;
    endproperty
    a_sample_at_seg1_end: assert property (p_sample_at_seg1_end) else $error("sample not at segment boundary");

    property p_single_sample;
        @(posedge mclk) disable iff (reset)
        (samplePoint && !segments.tripleSampleSelect && $stable(segments)) |-> rxBit == $past(s.rxSync);
    endproperty
    a_single_sample: assert property (p_single_sample) else $error("single sample value wrong");

    property p_triple_sample;
        @(posedge mclk) disable iff (reset)
        (samplePoint && segments.tripleSampleSelect && $stable(segments)) |-> rxBit == $past(voteBit);
    endproperty
    a_triple_sample: assert property (p_triple_sample) else $error("triple sample vote wrong");

    property p_sync_one_quantum;
        @(posedge mclk) disable iff (reset)
        (s.phase == cbt_pkg::CBT_SYNC && quantumTick) |=> s.phase == cbt_pkg::CBT_SEG1 && s.tqCnt == 4'h0;
    endproperty
    a_sync_one_quantum: assert property (p_sync_one_quantum) else $error("sync segment not one quantum");

    property p_write_taken;
        @(posedge mclk) disable iff (reset)
        (cmdValid && cmdOpcode == `CBT_OPC_WRITE && modeField[`CBT_MODE_INIT_BIT])
        |=> (segments == $past(cmdWrData)) && !wrRefused;
    endproperty
    a_write_taken: assert property (p_write_taken) else $error("write in init mode not taken");

    property p_refusal_cause;
        @(posedge mclk) disable iff (reset)
        wrRefused |-> $past(cmdValid) && $past(cmdOpcode) == `CBT_OPC_WRITE && !$past(modeField[`CBT_MODE_INIT_BIT]);
    endproperty
    a_refusal_cause: assert property (p_refusal_cause) else $error("refusal without a blocked write");

    property p_seg1_end;
        @(posedge mclk) disable iff (reset)
        (s.phase == cbt_pkg::CBT_SEG1 && quantumTick && {1'b0, s.tqCnt} == len1 - 5'h01)
        |=> (s.phase == cbt_pkg::CBT_SEG2) && samplePoint;
    endproperty
    a_seg1_end: assert property (p_seg1_end) else $error("first segment ran too long");

    property p_seg2_early;
        @(posedge mclk) disable iff (reset)
        (s.phase == cbt_pkg::CBT_SEG2 && quantumTick && {1'b0, s.tqCnt} < len2 - 5'h01)
        |=> (s.phase == cbt_pkg::CBT_SEG2) && !bitStart;
    endproperty
    a_seg2_early: assert property (p_seg2_early) else $error("second segment ended early");

    property p_sample_on_tick;
        @(posedge mclk) disable iff (reset)
        samplePoint |-> $past(quantumTick);
    endproperty
    a_sample_on_tick: assert property (p_sample_on_tick) else $error("sample point off a quantum edge");

    property p_bit_start_on_tick;
        @(posedge mclk) disable iff (reset)
        bitStart |-> $past(quantumTick) && s.phase == cbt_pkg::CBT_SYNC;
    endproperty
    a_bit_start_on_tick: assert property (p_bit_start_on_tick) else $error("bit start off sync quantum");

endmodule

// >>> cbt_map.svh
`ifndef CBT_MAP_SVH
`define CBT_MAP_SVH

// Register access command codes
`define CBT_OPC_WRITE     8'h1a
`define CBT_OPC_READ      8'hd8

// Register reset value and field layout
`define CBT_REG_RESET     8'h00
`define CBT_TRIPLE_BIT    7
`define CBT_SEG2_MSB      6
`define CBT_SEG2_LSB      4
`define CBT_SEG1_MSB      3
`define CBT_SEG1_LSB      0

// Primary control mode field: the top bit flags init mode
`define CBT_MODE_INIT_BIT 2

// Least legal nominal bit time in quanta
`define CBT_MIN_BIT_TQ    5'h08

`endif

// >>> cbt_pkg.sv
package cbt_pkg;

    // Layout of the segment timing register
    typedef struct packed {
        logic       tripleSampleSelect;
        logic [2:0] secondSegmentLen;
        logic [3:0] firstSegmentLen;
    } cbt_segments_t;

    // Bit time phases, Gray coded along sync, seg1, seg2
    typedef enum logic [1:0] {
        CBT_SYNC = 2'b00,
        CBT_SEG1 = 2'b01,
        CBT_SEG2 = 2'b11
    } cbt_phase_t;

    // Main block state
    typedef struct packed {
        logic          rxMeta;
        logic          rxSync;
        cbt_segments_t segments;
        cbt_phase_t    phase;
        logic [3:0]    tqCnt;
        logic          samplePoint;
        logic          bitStart;
        logic          rxBit;
        logic [7:0]    rdData;
        logic          wrRefused;
        logic          cfgValid;
    } cbt_state_t;

    // Sampler history of the two previous quantum samples
    typedef struct packed {
        logic [1:0] hist;
    } cbt_hist_t;

    // Two of three vote
    function automatic logic cbt_majority(input logic [2:0] v);
        return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction

endpackage

// >>> cbt_sampler.sv
`timescale 1ns/10ps
`include "cbt_map.svh"

module cbt_sampler (
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic quantumTick,
    input  wire logic rxIn,
    output logic      voteBit
);

    cbt_pkg::cbt_hist_t s;
    cbt_pkg::cbt_hist_t n;

    ////////////////////////////////////////////////////////////////////////
    // Keep the last two quantum samples; the vote includes the current one
    always_comb begin
        n = s;
        if (quantumTick) begin
            n.hist = {s.hist[0], rxIn};
        end
    end

    // Vote over three consecutive quanta ending now
    assign voteBit = cbt_pkg::cbt_majority({s.hist, rxIn});

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

endmodule

// >>> cbt_bus_model.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Bus line behind the transceiver, may flip one chosen quantum of every bit
module cbt_bus_model (
    input  wire logic       mclk,
    input  wire logic       quantumTick,
    input  wire logic       bitStart,
    input  wire logic       level,
    input  wire logic       glitchEn,
    input  wire logic [3:0] glitchQ,
    output logic            canRx
);
    logic [4:0] qIdx;

    // Quantum index inside the bit, sync quantum is zero
    always_ff @(posedge mclk) begin
        if (bitStart) begin
            qIdx <= 5'h00;
        end else if (quantumTick) begin
            qIdx <= qIdx + 5'h01;
        end
    end

    // Short disturbance on the line, e.g. a noise spike near the sample point
    assign canRx = level ^ (glitchEn && qIdx == {1'b0, glitchQ});
endmodule

// >>> can_bit_timing_segments_bench.sv
`timescale 1ns/10ps
`include "cbt_map.svh"
module can_bit_timing_segments_bench;
    logic                   mclk, reset, cmdValid, canRxPin, level, glitchEn, refSeen;
    logic                   quantumTick = 1'b0;
    logic                   wrRefused, cfgValid, samplePoint, bitStart, rxBit;
    logic [7:0]             cmdOpcode, cmdWrData, rdData;
    logic [2:0]             modeField;
    logic [3:0]             glitchQ;
    logic [1:0]             tickCnt = 2'h0;
    cbt_pkg::cbt_segments_t segments;
    int                     errors, checksDone, a, b, i;
    int                     cycles = 0;
    logic [7:0]             vals [7] = '{8'h13, 8'h33, 8'h07, 8'h70, 8'h21, 8'h12, 8'h7f};

    cbt_bit_timing u_dut (.mclk(mclk), .reset(reset), .cmdValid(cmdValid), .cmdOpcode(cmdOpcode),
        .cmdWrData(cmdWrData), .modeField(modeField), .quantumTick(quantumTick), .canRxPin(canRxPin),
        .rdData(rdData), .wrRefused(wrRefused), .segments(segments), .cfgValid(cfgValid),
        .samplePoint(samplePoint), .bitStart(bitStart), .rxBit(rxBit));
    cbt_bus_model u_bus (.mclk(mclk), .quantumTick(quantumTick), .bitStart(bitStart), .level(level),
        .glitchEn(glitchEn), .glitchQ(glitchQ), .canRx(canRxPin));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, prescaler stand-in ticking every 4 cycles, hang guard
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(negedge mclk) begin
        tickCnt <= tickCnt + 2'h1;
        quantumTick <= (tickCnt == 2'h2);
    end
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            errors = errors + 1;
            testDone();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checksDone = checksDone + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One command cycle; refusal pulse is caught in the cycle after
    task automatic cmd(input logic [7:0] op, input logic [7:0] d);
        @(negedge mclk);
        cmdValid = 1'b1;
        cmdOpcode = op;
        cmdWrData = d;
        @(negedge mclk);
        cmdValid = 1'b0;
        refSeen = wrRefused;
    endtask
    // Bounded wait for bitStart (sel 0) or samplePoint (sel 1)
    task automatic waitFor(input bit sel, output int n);
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (((sel ? samplePoint : bitStart) !== 1'b1) && n < 300);
        chk("pulse wait", 16'h0001, {15'h0, n < 300});
    endtask
    function automatic logic expValid(input logic [7:0] d);
        int l1, l2;
        l1 = d[3:0] + 1;
        l2 = d[6:4] + 1;
        return d[3:0] != 0 && d[6:4] != 0 && l1 >= l2 && 1 + l1 + l2 >= 8;
    endfunction
    // Lengths of sync plus first segment and of the whole bit, in cycles
    task automatic timing(input logic [7:0] d);
        cmd(`CBT_OPC_WRITE, d);
        waitFor(0, a);
        waitFor(0, a);
        waitFor(1, a);
        waitFor(0, b);
        chk("sample offset", 16'(4 * (2 + d[3:0])), 16'(a));
        chk("bit length", 16'(4 * (3 + d[3:0] + d[6:4])), 16'(a + b));
    endtask
    // Single quantum flip at index q of each bit, then the received value
    task automatic sampleTest(input logic [7:0] d, input logic [3:0] q, input logic exp);
        cmd(`CBT_OPC_WRITE, d);
        glitchQ = q;
        glitchEn = 1'b1;
        waitFor(0, a);
        waitFor(0, a);
        waitFor(1, a);
        chk("rxBit", {15'h0, exp}, {15'h0, rxBit});
        glitchEn = 1'b0;
    endtask
    task automatic testDone();
        $display("checks %0d mismatches %0d", checksDone, errors);
        if (errors == 0 && checksDone > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {reset, cmdValid, level, glitchEn} = 4'b1010;
        {cmdOpcode, cmdWrData, glitchQ, modeField} = {8'h00, 8'h00, 4'h0, 3'h4};
        errors = 0;
        checksDone = 0;
        repeat (20) @(negedge mclk);
        reset = 1'b0;
        cmd(`CBT_OPC_READ, 8'h00);
        chk("reset read", 16'h0000, {8'h00, rdData});
        chk("reset segments", 16'h0000, {8'h00, segments});
        modeField = 3'h7;
        cmd(`CBT_OPC_WRITE, 8'hb5);
        chk("write in init", 16'h00b5, {8'h00, segments});
        chk("no refusal", 16'h0000, {15'h0, refSeen});
        cmd(`CBT_OPC_READ, 8'h00);
        chk("read back", 16'h00b5, {8'h00, rdData});
        cmd(8'h26, 8'h00);
        chk("unknown opcode", 16'h00b5, {8'h00, segments});
        modeField = 3'h3;
        cmd(`CBT_OPC_WRITE, 8'h11);
        chk("refused write", 16'h0001, {15'h0, refSeen});
        chk("value kept", 16'h00b5, {8'h00, segments});
        modeField = 3'h4;
        $display("test registers done");
        for (i = 0; i < 7; i++) begin
            cmd(`CBT_OPC_WRITE, vals[i]);
            chk("cfgValid", {15'h0, expValid(vals[i])}, {15'h0, cfgValid});
        end
        $display("test validity done");
        timing(8'h14);
        timing(8'h1f);
        timing(8'h77);
        timing(8'h7f);
        timing(8'h23);
        $display("test timing done");
        sampleTest(8'h23, 4'h4, 1'b0);
        sampleTest(8'h23, 4'h3, 1'b1);
        sampleTest(8'ha3, 4'h4, 1'b1);
        level = 1'b0;
        sampleTest(8'ha3, 4'h2, 1'b0);
        $display("test sampling done");
        testDone();
    end
endmodule
